//--- rtl/mfio_port.sv
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module mfio_port (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [31:0] rdata,
    input wire logic [6:0] pin_in,
    output logic [6:0] pin_out,
    output logic [6:0] pin_oe,
    input wire logic [69:0] adc_result,
    input wire logic link_data_out,
    input wire logic link_data_oe,
    input wire logic link_clk_out,
    input wire logic link_clk_oe,
    input wire logic go_sync_out,
    input wire logic go_sync_oe,
    output logic link_data_in,
    output logic link_clk_in,
    output logic go_sync_in,
    output logic right_limit_active,
    output logic left_limit_active
);

    mfio_level_if lv ();

    mfio_pkg::mfio_mode_t mode_reg [7];
    mfio_pkg::mfio_mode_t mode_next [7];
    logic [6:0] latch_reg;
    logic [6:0] latch_next;
    logic limit_high_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic [6:0] pin_out_reg;
    logic [6:0] pin_out_next;
    logic [6:0] pin_oe_reg;
    logic [6:0] pin_oe_next;
    logic link_data_in_reg;
    logic link_clk_in_reg;
    logic go_sync_in_reg;
    logic right_limit_reg;
    logic left_limit_reg;

    // address decode
    logic hit_latch;
    logic hit_set_input;
    logic hit_set_output;
    logic hit_restore;
    logic hit_config;
    logic hit_level;
    logic hit_mode;
    logic hit_latches;
    logic hit_analog;
    logic [2:0] latch_idx;
    logic [2:0] analog_idx;
    logic wr_latch;
    logic wr_set_input;
    logic wr_set_output;
    logic wr_restore;
    logic wr_config;
    logic [6:0] input_mask;
    logic [6:0] output_mask;
    logic [6:0] restore_mask;
    logic [9:0] analog_sel;
    logic [20:0] mode_word;

    assign hit_latch = mfio_pkg::in_slot(addr, mfio_pkg::OFS_LATCH_BASE);
    assign hit_analog = mfio_pkg::in_slot(addr, mfio_pkg::OFS_ANALOG_BASE);
    assign latch_idx = mfio_pkg::slot_index(addr, mfio_pkg::OFS_LATCH_BASE);
    assign analog_idx =
        mfio_pkg::slot_index(addr, mfio_pkg::OFS_ANALOG_BASE);
    assign hit_set_input = (addr == mfio_pkg::OFS_SET_INPUT);
    assign hit_set_output = (addr == mfio_pkg::OFS_SET_OUTPUT);
    assign hit_restore = (addr == mfio_pkg::OFS_RESTORE);
    assign hit_config = (addr == mfio_pkg::OFS_CONFIG);
    assign hit_level = (addr == mfio_pkg::OFS_LEVEL);
    assign hit_mode = (addr == mfio_pkg::OFS_MODE);
    assign hit_latches = (addr == mfio_pkg::OFS_LATCHES);

    assign wr_latch = wr_stb && hit_latch;
    assign wr_set_input = wr_stb && hit_set_input;
    assign wr_set_output = wr_stb && hit_set_output;
    assign wr_restore = wr_stb && hit_restore;
    assign wr_config = wr_stb && hit_config;

    // any pin may take any general function at any moment
    assign input_mask = wr_set_input ? wdata[6:0] : 7'h00;
    assign output_mask = wr_set_output ? wdata[6:0] : 7'h00;
    // only C, D, E, F and G have a role to return to
    assign restore_mask = wr_restore ?
        (wdata[6:0] & mfio_pkg::SPECIAL_CAPABLE) : 7'h00;

    // conversion results of all seven pins, ten bits each
    assign analog_sel = adc_result[analog_idx * 10 +: 10];

    always_comb begin
        mode_word = 21'h000000;
        for (int i = 0; i < mfio_pkg::NUM_PINS; i++) begin
            mode_word[i * 3 +: 3] = mode_reg[i];
        end
    end

    assign lv.limit_high = limit_high_reg;

    mfio_pin_sync u_sync (
        .clk(clk),
        .rst(rst),
        .pin_in(pin_in),
        .lv(lv)
    );

    // latch update: bit zero of the written value only
    always_comb begin
        latch_next = latch_reg;
        if (wr_latch) begin
            latch_next[latch_idx] = wdata[0];
        end
    end

    // function selection per pin
    always_comb begin
        for (int i = 0; i < mfio_pkg::NUM_PINS; i++) begin
            mode_next[i] = mode_reg[i];
            if (input_mask[i]) begin
                mode_next[i] = mfio_pkg::MFIO_MODE_IN;
            end else if (output_mask[i]) begin
                mode_next[i] = mfio_pkg::MFIO_MODE_OUT;
            end else if (restore_mask[i]) begin
                mode_next[i] = mfio_pkg::MFIO_MODE_SPECIAL;
            end
        end
    end

    // pin drivers from function, latch and special roles
    always_comb begin
        pin_out_next = 7'h00;
        pin_oe_next = 7'h00;
        for (int i = 0; i < mfio_pkg::NUM_PINS; i++) begin
            case (mode_reg[i])
                mfio_pkg::MFIO_MODE_IN: begin
                    pin_out_next[i] = 1'b0;
                    pin_oe_next[i] = 1'b0;
                end
                mfio_pkg::MFIO_MODE_OUT: begin
                    pin_out_next[i] = latch_reg[i];
                    pin_oe_next[i] = 1'b1;
                end
                mfio_pkg::MFIO_MODE_SPECIAL: begin
                    if (i == mfio_pkg::PIN_E) begin
                        pin_out_next[i] = link_data_out;
                        pin_oe_next[i] = link_data_oe;
                    end else if (i == mfio_pkg::PIN_F) begin
                        pin_out_next[i] = link_clk_out;
                        pin_oe_next[i] = link_clk_oe;
                    end else if (i == mfio_pkg::PIN_G) begin
                        pin_out_next[i] = go_sync_out;
                        pin_oe_next[i] = go_sync_oe;
                    end else begin
                        pin_out_next[i] = 1'b0;
                        pin_oe_next[i] = 1'b0;
                    end
                end
                default: begin
                    pin_out_next[i] = 1'b0;
                    pin_oe_next[i] = 1'b0;
                end
            endcase
        end
    end

    // read answer, valid in the cycle after the strobe only
    always_comb begin
        rdata_next = 32'h00000000;
        if (rd_stb) begin
            if (hit_latch) begin
                rdata_next = {31'h00000000, latch_reg[latch_idx]};
            end else if (hit_analog) begin
                rdata_next = {22'h000000, analog_sel};
            end else if (hit_level) begin
                rdata_next = {25'h0000000, lv.level};
            end else if (hit_mode) begin
                rdata_next = {11'h000, mode_word};
            end else if (hit_latches) begin
                rdata_next = {25'h0000000, latch_reg};
            end else if (hit_config) begin
                rdata_next = {31'h00000000, limit_high_reg};
            end else begin
                rdata_next = 32'h00000000;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < mfio_pkg::NUM_PINS; i++) begin
                mode_reg[i] <= mfio_pkg::RESET_SPECIAL[i] ?
                    mfio_pkg::MFIO_MODE_SPECIAL :
                    mfio_pkg::MFIO_MODE_IN;
            end
        end else begin
            for (int i = 0; i < mfio_pkg::NUM_PINS; i++) begin
                mode_reg[i] <= mode_next[i];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            latch_reg <= mfio_pkg::RESET_LATCH;
            limit_high_reg <= mfio_pkg::RESET_LIMIT_HIGH;
        end else begin
            latch_reg <= latch_next;
            if (wr_config) begin
                limit_high_reg <= wdata[mfio_pkg::CFG_LIMIT_HIGH_BIT];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pin_out_reg <= 7'h00;
            pin_oe_reg <= 7'h00;
            rdata_reg <= 32'h00000000;
        end else begin
            pin_out_reg <= pin_out_next;
            pin_oe_reg <= pin_oe_next;
            rdata_reg <= rdata_next;
        end
    end

    // role inputs follow the pin only while the pin holds its role
    always_ff @(posedge clk) begin
        if (rst) begin
            link_data_in_reg <= mfio_pkg::LINK_IDLE_LEVEL;
            link_clk_in_reg <= mfio_pkg::LINK_IDLE_LEVEL;
            go_sync_in_reg <= mfio_pkg::LINK_IDLE_LEVEL;
            right_limit_reg <= 1'b0;
            left_limit_reg <= 1'b0;
        end else begin
            link_data_in_reg <=
                (mode_reg[mfio_pkg::PIN_E] == mfio_pkg::MFIO_MODE_SPECIAL) ?
                lv.level[mfio_pkg::PIN_E] : mfio_pkg::LINK_IDLE_LEVEL;
            link_clk_in_reg <=
                (mode_reg[mfio_pkg::PIN_F] == mfio_pkg::MFIO_MODE_SPECIAL) ?
                lv.level[mfio_pkg::PIN_F] : mfio_pkg::LINK_IDLE_LEVEL;
            go_sync_in_reg <=
                (mode_reg[mfio_pkg::PIN_G] == mfio_pkg::MFIO_MODE_SPECIAL) ?
                lv.level[mfio_pkg::PIN_G] : mfio_pkg::LINK_IDLE_LEVEL;
            right_limit_reg <=
                (mode_reg[mfio_pkg::PIN_C] == mfio_pkg::MFIO_MODE_SPECIAL) &&
                lv.right_hit;
            left_limit_reg <=
                (mode_reg[mfio_pkg::PIN_D] == mfio_pkg::MFIO_MODE_SPECIAL) &&
                lv.left_hit;
        end
    end

    assign rdata = rdata_reg;
    assign pin_out = pin_out_reg;
    assign pin_oe = pin_oe_reg;
    assign link_data_in = link_data_in_reg;
    assign link_clk_in = link_clk_in_reg;
    assign go_sync_in = go_sync_in_reg;
    assign right_limit_active = right_limit_reg;
    assign left_limit_active = left_limit_reg;

endmodule

//--- include/mfio_pkg.sv
package mfio_pkg;

    localparam int NUM_PINS = 7;
    localparam int ADC_BITS = 10;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // pin positions on the port
    localparam int PIN_A = 0;
    localparam int PIN_B = 1;
    localparam int PIN_C = 2;
    localparam int PIN_D = 3;
    localparam int PIN_E = 4;
    localparam int PIN_F = 5;
    localparam int PIN_G = 6;

    // register byte offsets
    localparam logic [7:0] OFS_LATCH_BASE = 8'h00;
    localparam logic [7:0] OFS_SET_INPUT = 8'h20;
    localparam logic [7:0] OFS_SET_OUTPUT = 8'h24;
    localparam logic [7:0] OFS_RESTORE = 8'h28;
    localparam logic [7:0] OFS_CONFIG = 8'h2C;
    localparam logic [7:0] OFS_LEVEL = 8'h30;
    localparam logic [7:0] OFS_MODE = 8'h34;
    localparam logic [7:0] OFS_LATCHES = 8'h38;
    localparam logic [7:0] OFS_ANALOG_BASE = 8'h40;
    localparam logic [7:0] SLOT_SPAN = 8'h1C;

    // field positions and reset values
    localparam int CFG_LIMIT_HIGH_BIT = 0;
    localparam logic [6:0] SPECIAL_CAPABLE = 7'h7C;
    localparam logic [6:0] RESET_SPECIAL = 7'h4C;
    localparam logic [6:0] RESET_LATCH = 7'h00;
    localparam logic RESET_LIMIT_HIGH = 1'b0;
    localparam logic LINK_IDLE_LEVEL = 1'b1;

    typedef enum logic [2:0] {
        MFIO_MODE_IN = 3'b001,
        MFIO_MODE_OUT = 3'b010,
        MFIO_MODE_SPECIAL = 3'b100
    } mfio_mode_t;

    // word slot inside a block of seven registers
    function automatic logic in_slot(input logic [7:0] addr,
                                     input logic [7:0] base);
        logic [7:0] rel;
        rel = addr - base;
        in_slot = (addr >= base) && (rel < SLOT_SPAN) &&
                  (addr[1:0] == 2'h0);
    endfunction

    function automatic logic [2:0] slot_index(input logic [7:0] addr,
                                              input logic [7:0] base);
        logic [7:0] rel;
        rel = addr - base;
        slot_index = rel[4:2];
    endfunction

endpackage

//--- include/mfio_level_if.sv
`timescale 1ns/1ps
interface mfio_level_if;
    logic [6:0] level;
    logic limit_high;
    logic right_hit;
    logic left_hit;

    modport sync (
        input limit_high,
        output level,
        output right_hit,
        output left_hit
    );

    modport core (
        output limit_high,
        input level,
        input right_hit,
        input left_hit
    );
endinterface

//--- rtl/mfio_pin_sync.sv
`timescale 1ns/1ps
module mfio_pin_sync (
    input wire logic clk,
    input wire logic rst,
    input wire logic [6:0] pin_in,
    mfio_level_if.sync lv
);

    logic [6:0] meta_reg;
    logic [6:0] level_reg;
    logic right_raw;
    logic left_raw;

    // idle level is high through the pad pull-up, low is active unless limit_high is set
    assign right_raw = lv.limit_high ? level_reg[mfio_pkg::PIN_C]
                                     : ~level_reg[mfio_pkg::PIN_C];
    assign left_raw = lv.limit_high ? level_reg[mfio_pkg::PIN_D]
                                    : ~level_reg[mfio_pkg::PIN_D];

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_reg <= 7'h7F;
            level_reg <= 7'h7F;
        end else begin
            meta_reg <= pin_in;
            level_reg <= meta_reg;
        end
    end

    assign lv.level = level_reg;
    assign lv.right_hit = right_raw;
    assign lv.left_hit = left_raw;

endmodule

//--- bench/mfio_field_model.sv
`timescale 1ns/1ps
module mfio_field_model (
    input wire logic [6:0] pin_out,
    input wire logic [6:0] pin_oe,
    input wire logic [6:0] pull_low,
    output logic [6:0] pin_in
);
    // released lines float high through the pull-up
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ~pull_low);
endmodule

//--- bench/mfio_port_asserts.sv
`timescale 1ns/1ps
module mfio_port_asserts (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [31:0] rdata,
    input wire logic [6:0] pin_in,
    input wire logic [6:0] pin_out,
    input wire logic [6:0] pin_oe,
    input wire logic [69:0] adc_result,
    input wire logic link_data_in,
    input wire logic link_clk_in,
    input wire logic go_sync_in,
    input wire logic right_limit_active,
    input wire logic left_limit_active
);
    logic [6:0] role_reg;
    logic hi_reg;
    logic [9:0] adc_reg;
    logic [7:0] rel;
    logic [6:0] mask;
    logic an_rd;
    assign rel = addr - 8'h40;
    assign mask = wdata[6:0];
    assign an_rd = rd_stb && addr >= 8'h40 && addr <= 8'h58 && !addr[1:0];
    always_ff @(posedge clk) begin
        adc_reg <= adc_result[10 * rel[4:2] +: 10];
        if (rst) begin
            role_reg <= 7'h4C;
            hi_reg <= 1'b0;
        end else if (wr_stb && (addr == 8'h20 || addr == 8'h24)) begin
            role_reg <= role_reg & ~mask;
        end else if (wr_stb && addr == 8'h28) begin
            role_reg <= role_reg | (mask & 7'h7C);
        end else if (wr_stb && addr == 8'h2C) begin
            hi_reg <= wdata[0];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence calm;
        ($stable(pin_in) && $stable(role_reg) && $stable(hi_reg))[*6];
    endsequence
    chk_output_on: assert property (
        wr_stb && addr == 8'h24 |-> ##2 (pin_oe & $past(mask, 2)) == $past(mask, 2))
        else $error("output enable not set");
    chk_input_off: assert property (
        wr_stb && addr == 8'h20 |-> ##2 (pin_oe & $past(mask, 2)) == 7'h00)
        else $error("output enable not cleared");
    chk_latch_lsb: assert property (
        rd_stb && addr <= 8'h18 && !addr[1:0] |=> rdata[31:1] == 31'h0)
        else $error("latch wider than one bit");
    chk_analog_read: assert property (
        an_rd |=> rdata == {22'h0, adc_reg})
        else $error("analog value wrong");
    chk_rdata_idle: assert property (!rd_stb |=> rdata == 32'h0)
        else $error("read data outside read cycle");
    chk_reset_values: assert property (
        $fell(rst) |-> pin_oe == 7'h00 && pin_out == 7'h00 &&
        !right_limit_active && !left_limit_active)
        else $error("reset values wrong");
    chk_right_limit: assert property (
        calm |-> right_limit_active == (role_reg[2] && pin_in[2] == hi_reg))
        else $error("right limit wrong");
    chk_left_limit: assert property (
        calm |-> left_limit_active == (role_reg[3] && pin_in[3] == hi_reg))
        else $error("left limit wrong");
    chk_go_sync: assert property (
        calm |-> go_sync_in == (!role_reg[6] || pin_in[6]))
        else $error("sync line wrong");
    chk_link_lines: assert property (
        calm |-> link_data_in == (!role_reg[4] || pin_in[4]) &&
        link_clk_in == (!role_reg[5] || pin_in[5]))
        else $error("link lines wrong");
endmodule
bind mfio_port mfio_port_asserts u_chk (.clk, .rst, .addr, .wdata, .wr_stb,
    .rd_stb, .rdata, .pin_in, .pin_out, .pin_oe, .adc_result, .link_data_in,
    .link_clk_in, .go_sync_in, .right_limit_active, .left_limit_active);

//--- bench/test_mfio_port.sv
`timescale 1ns/1ps
module test_mfio_port;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h0;
    logic [31:0] wdata = 32'h0, rdata, v;
    logic [31:0] seed = 32'h7CF5;
    logic wr_stb = 1'b0, rd_stb = 1'b0;
    logic [6:0] pin_in, pin_out, pin_oe, lm, role_m, out_m;
    logic [6:0] pull = 7'h0;
    logic [5:0] lnk = 6'h0;
    logic [69:0] adc = 70'h0;
    logic ldi, lci, gsi, rla, lla;
    int n_fail = 0, checks = 0, cyc = 0, i, k;
    always #2.5 clk = ~clk;
    mfio_port i_dut (.clk, .rst, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
        .pin_in, .pin_out, .pin_oe, .adc_result(adc),
        .link_data_out(lnk[0]), .link_data_oe(lnk[1]),
        .link_clk_out(lnk[2]), .link_clk_oe(lnk[3]),
        .go_sync_out(lnk[4]), .go_sync_oe(lnk[5]), .link_data_in(ldi),
        .link_clk_in(lci), .go_sync_in(gsi), .right_limit_active(rla),
        .left_limit_active(lla));
    mfio_field_model u_field (.pin_out, .pin_oe, .pull_low(pull), .pin_in);
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [31:0] mode_word();
        logic [31:0] f;
        f = 32'h0;
        for (int p = 0; p < 7; p++) begin
            f[3*p +: 3] = role_m[p] ? 3'h4 : out_m[p] ? 3'h2 : 3'h1;
        end
        return f;
    endfunction
    task tally_and_finish();
        if (n_fail == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
        checks++;
        if (seen !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, e, seen);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask
    task rc(input logic [7:0] a, input string nm, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1 chk(nm, rdata, e);
    endtask
    task settle();
        repeat (6) @(posedge clk);
        #1;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        role_m = 7'h4C;
        out_m = 7'h0;
        lm = 7'h0;
        rc(8'h34, "mode", mode_word());
        rc(8'h38, "latches", 32'h0);
        chk("oe", {25'h0, pin_oe}, 32'h0);
        for (i = 0; i < 7; i++) begin
            v = xs();
            lm[i] = v[0];
            wr(8'(4 * i), v);
            rc(8'(4 * i), "latch", {31'h0, v[0]});
        end
        rc(8'h38, "latches", {25'h0, lm});
        wr(8'h24, 32'h7F);
        role_m = 7'h0;
        out_m = 7'h7F;
        settle();
        chk("oe", {25'h0, pin_oe}, 32'h7F);
        chk("out", {25'h0, pin_out}, {25'h0, lm});
        rc(8'h34, "mode", mode_word());
        lm[1] = ~lm[1];
        wr(8'h04, {31'h0, lm[1]});
        settle();
        chk("out", {25'h0, pin_out}, {25'h0, lm});
        rc(8'h30, "level", {25'h0, lm});
        wr(8'h20, 32'h7F);
        out_m = 7'h0;
        settle();
        chk("oe", {25'h0, pin_oe}, 32'h0);
        for (i = 0; i < 6; i++) begin
            v = xs();
            @(posedge clk);
            pull <= v[6:0];
            adc <= (i == 0) ? {70{1'b1}} : {v[5:0], xs(), xs()};
            settle();
            rc(8'h30, "level", {25'h0, ~pull});
            for (k = 0; k < 7; k++) begin
                rc(8'(8'h40 + 4 * k), "adc", {22'h0, adc[10*k +: 10]});
            end
        end
        wr(8'h28, 32'h7F);
        role_m = 7'h7C;
        for (i = 0; i < 8; i++) begin
            wr(8'h2C, {31'h0, i[0]});
            v = xs();
            @(posedge clk);
            pull <= v[6:0];
            lnk <= v[12:7];
            settle();
            chk("right", {31'h0, rla}, {31'h0, !pull[2] == i[0]});
            chk("left", {31'h0, lla}, {31'h0, !pull[3] == i[0]});
            chk("go", {31'h0, gsi}, {31'h0, pin_in[6]});
            chk("link", {30'h0, lci, ldi}, {30'h0, pin_in[5:4]});
            chk("oe", {25'h0, pin_oe}, {25'h0, lnk[5], lnk[3], lnk[1], 4'h0});
        end
        rc(8'h34, "mode", mode_word());
        wr(8'h2C, 32'h0);
        wr(8'h20, 32'h7C);
        role_m = 7'h0;
        @(posedge clk);
        pull <= 7'h7F;
        settle();
        chk("roles", {27'h0, rla, lla, gsi, lci, ldi}, 32'h7);
        wr(8'h34, 32'h0);
        rc(8'h34, "mode", mode_word());
        wr(8'hFC, 32'hFFFFFFFF);
        rc(8'hFC, "unmapped", 32'h0);
        rc(8'h38, "latches", {25'h0, lm});
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        role_m = 7'h4C;
        out_m = 7'h0;
        rc(8'h34, "mode", mode_word());
        rc(8'h38, "latches", 32'h0);
        tally_and_finish();
    end
endmodule
